// ---- logic/pll_serial_control_regs.v ----
/*
 holds: the serial-port control bank of the loop: port setup, readback
 select, buffer transfer and the pump / phase detector override fields.
 assumes: a serial shifter outside turns frames into byte writes and reads
 on this clock; it uses lsb_first to order its bits and bytes.
*/
`timescale 1ns/1ps
`default_nettype none

`include "pll_regs_defines.vh"

module pll_serial_control_regs (
   input wire clock,
   input wire rst,
   input wire wr_en,
   input wire rd_en,
   input wire [7:0] addr,
   input wire [7:0] wr_data,
   output reg [7:0] rd_data,
   output reg rd_valid,
   output wire lsb_first,
   output reg pump_current_override,
   output reg [7:0] pump_current,
   output reg pump_drive_mode_override,
   output reg [1:0] pump_drive_mode,
   output reg antibacklash_override,
   output reg [1:0] antibacklash_period,
   output reg phase_detector_fb_falling,
   output reg phase_detector_ref_falling,
   output reg tuned_oscillator_midscale,
   output reg offset_override,
   output reg offset_pump_down,
   output reg [1:0] offset_magnitude,
   output reg [7:0] offset_current,
   output reg lockdet_power_down
);

   // ----------------------------------------
   // write decode
   // ----------------------------------------
   wire wr_cfg;
   wire wr_readback;
   wire wr_xfer;
   wire wr_code;
   wire wr_loop;
   wire wr_ofs;
   wire wr_abl;

   // unmapped offsets match no strobe, so writes to them fall away
   assign wr_cfg = wr_en && (addr == `ADDR_PORT_CFG);
   assign wr_readback = wr_en && (addr == `ADDR_READBACK);
   assign wr_xfer = wr_en && (addr == `ADDR_TRANSFER);
   assign wr_code = wr_en && (addr == `ADDR_PUMP_CODE);
   assign wr_loop = wr_en && (addr == `ADDR_LOOP_CTRL);
   assign wr_ofs = wr_en && (addr == `ADDR_OFFSET);
   assign wr_abl = wr_en && (addr == `ADDR_ABL);

   // ----------------------------------------
   // immediate registers
   // ----------------------------------------
   reg lsb_first_q;
   reg readback_buffered_q;
   wire soft_reset;
   wire transfer;
   wire bank_rst;

   // soft reset is a one-cycle pulse, so the bit reads back as zero
   assign soft_reset = wr_cfg && wr_data[`CFG_SOFT_RESET];
   assign transfer = wr_xfer && wr_data[`XFER_START];
   assign bank_rst = rst | soft_reset;
   assign lsb_first = lsb_first_q;

   always @(posedge clock) begin
      if (bank_rst) begin
         lsb_first_q <= 1'b0;
         readback_buffered_q <= 1'b0;
      end else begin
         if (wr_cfg) begin
            lsb_first_q <= wr_data[`CFG_LSB_FIRST];
         end
         if (wr_readback) begin
            readback_buffered_q <= wr_data[`READBACK_SEL];
         end
      end
   end

   // ----------------------------------------
   // buffered registers
   // ----------------------------------------
   wire [7:0] code_buf;
   wire [7:0] code_act;
   wire [7:0] loop_buf;
   wire [7:0] loop_act;
   wire [7:0] ofs_buf;
   wire [7:0] ofs_act;
   wire [7:0] abl_buf;
   wire [7:0] abl_act;

   buffered_reg #(.RESET_VALUE(`RST_PUMP_CODE), .WRITE_MASK(8'hFF)) u_code (
      .clock(clock),
      .rst(bank_rst),
      .wr_en(wr_code),
      .wr_data(wr_data),
      .transfer(transfer),
      .buffer_q(code_buf),
      .active_q(code_act)
   );

   buffered_reg #(.RESET_VALUE(`RST_LOOP_CTRL),
      .WRITE_MASK(`MASK_LOOP_CTRL)) u_loop (
      .clock(clock),
      .rst(bank_rst),
      .wr_en(wr_loop),
      .wr_data(wr_data),
      .transfer(transfer),
      .buffer_q(loop_buf),
      .active_q(loop_act)
   );

   buffered_reg #(.RESET_VALUE(`RST_OFFSET), .WRITE_MASK(`MASK_OFFSET)) u_ofs (
      .clock(clock),
      .rst(bank_rst),
      .wr_en(wr_ofs),
      .wr_data(wr_data),
      .transfer(transfer),
      .buffer_q(ofs_buf),
      .active_q(ofs_act)
   );

   buffered_reg #(.RESET_VALUE(`RST_ABL), .WRITE_MASK(`MASK_ABL)) u_abl (
      .clock(clock),
      .rst(bank_rst),
      .wr_en(wr_abl),
      .wr_data(wr_data),
      .transfer(transfer),
      .buffer_q(abl_buf),
      .active_q(abl_act)
   );

   // ----------------------------------------
   // control outputs
   // ----------------------------------------
   // without an override the outputs show the automatic value, the
   // reset default, so the analog side never sees a stale manual code
   reg [7:0] offset_d;
   reg pump_current_override_d;
   reg [7:0] pump_current_d;
   reg pump_drive_mode_override_d;
   reg [1:0] pump_drive_mode_d;
   reg antibacklash_override_d;
   reg [1:0] antibacklash_period_d;
   reg phase_detector_fb_falling_d;
   reg phase_detector_ref_falling_d;
   reg tuned_oscillator_midscale_d;
   reg offset_override_d;
   reg offset_pump_down_d;
   reg [1:0] offset_magnitude_d;
   reg [7:0] offset_current_d;
   reg lockdet_power_down_d;

   always @* begin
      case (ofs_act[`OFS_MAG_HI:`OFS_MAG_LO])
         2'b00: offset_d = {1'b0, code_act[7:1]};
         2'b01: offset_d = {2'b00, code_act[7:2]};
         2'b10: offset_d = {3'b000, code_act[7:3]};
         2'b11: offset_d = {4'h0, code_act[7:4]};
         default: offset_d = 8'h00;
      endcase
   end

   // pump current and pump mode
   always @* begin
      pump_current_override_d = loop_act[`LOOP_PUMP_OVR];
      if (loop_act[`LOOP_PUMP_OVR]) begin
         pump_current_d = code_act;
      end else begin
         pump_current_d = `RST_PUMP_CODE;
      end
      pump_drive_mode_override_d = loop_act[`LOOP_MODE_OVR];
      if (loop_act[`LOOP_MODE_OVR]) begin
         pump_drive_mode_d = loop_act[`LOOP_MODE_HI:`LOOP_MODE_LO];
      end else begin
         pump_drive_mode_d = `PUMP_MODE_NORMAL;
      end
   end

   // phase detector, antibacklash, oscillator and lock detector
   always @* begin
      antibacklash_override_d = loop_act[`LOOP_ABL_OVR];
      if (loop_act[`LOOP_ABL_OVR]) begin
         antibacklash_period_d = abl_act[`ABL_HI:`ABL_LO];
      end else begin
         antibacklash_period_d = `ABL_MINIMUM;
      end
      phase_detector_fb_falling_d = loop_act[`LOOP_FB_EDGE];
      phase_detector_ref_falling_d = loop_act[`LOOP_REF_EDGE];
      tuned_oscillator_midscale_d = loop_act[`LOOP_MIDSCALE];
      lockdet_power_down_d = abl_act[`ABL_LOCKDET_PD];
   end

   // offset direction and size count only under manual control
   always @* begin
      offset_override_d = ofs_act[`OFS_OVR];
      if (ofs_act[`OFS_OVR]) begin
         offset_pump_down_d = ofs_act[`OFS_POLARITY];
         offset_magnitude_d = ofs_act[`OFS_MAG_HI:`OFS_MAG_LO];
         offset_current_d = offset_d;
      end else begin
         offset_pump_down_d = 1'b0;
         offset_magnitude_d = 2'b00;
         offset_current_d = 8'h00;
      end
   end

   always @(posedge clock) begin
      if (bank_rst) begin
         pump_current_override <= 1'b0;
         pump_current <= `RST_PUMP_CODE;
         pump_drive_mode_override <= 1'b0;
         pump_drive_mode <= `PUMP_MODE_NORMAL;
         antibacklash_override <= 1'b0;
         antibacklash_period <= `ABL_MINIMUM;
         phase_detector_fb_falling <= 1'b0;
         phase_detector_ref_falling <= 1'b0;
         tuned_oscillator_midscale <= 1'b0;
         offset_override <= 1'b0;
         offset_pump_down <= 1'b0;
         offset_magnitude <= 2'b00;
         offset_current <= 8'h00;
         lockdet_power_down <= 1'b0;
      end else begin
         pump_current_override <= pump_current_override_d;
         pump_current <= pump_current_d;
         pump_drive_mode_override <= pump_drive_mode_override_d;
         pump_drive_mode <= pump_drive_mode_d;
         antibacklash_override <= antibacklash_override_d;
         antibacklash_period <= antibacklash_period_d;
         phase_detector_fb_falling <= phase_detector_fb_falling_d;
         phase_detector_ref_falling <= phase_detector_ref_falling_d;
         tuned_oscillator_midscale <= tuned_oscillator_midscale_d;
         offset_override <= offset_override_d;
         offset_pump_down <= offset_pump_down_d;
         offset_magnitude <= offset_magnitude_d;
         offset_current <= offset_current_d;
         lockdet_power_down <= lockdet_power_down_d;
      end
   end

   // ----------------------------------------
   // readback
   // ----------------------------------------
   // the read address is taken with rd_en, a cycle ahead of rd_valid
   reg [3:0] cfg_hi;
   reg [7:0] rd_d;

   always @* begin
      cfg_hi = {1'b0, lsb_first_q, 1'b0, 1'b1};
      case (addr)
         `ADDR_PORT_CFG: rd_d = {cfg_hi, cfg_hi};
         `ADDR_READBACK: rd_d = {7'h00, readback_buffered_q};
         `ADDR_TRANSFER: rd_d = 8'h00;
         `ADDR_PUMP_CODE: rd_d = readback_buffered_q ?
            code_buf : code_act;
         `ADDR_LOOP_CTRL: rd_d = readback_buffered_q ?
            loop_buf : loop_act;
         `ADDR_OFFSET: rd_d = readback_buffered_q ? ofs_buf : ofs_act;
         `ADDR_ABL: rd_d = readback_buffered_q ? abl_buf : abl_act;
         default: rd_d = 8'h00;
      endcase
   end

   // soft reset leaves the read port alone so a read in flight still
   // completes; rd_data holds until the next read
   always @(posedge clock) begin
      if (rst) begin
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= rd_en;
         if (rd_en) begin
            rd_data <= rd_d;
         end
      end
   end

endmodule // pll_serial_control_regs

`default_nettype wire

// ---- common/pll_regs_defines.vh ----
/*
 holds: offsets, field positions and reset values of the loop control
 register bank.
 assumes: included by bare name from the design files.
*/
`ifndef PLL_REGS_DEFINES_VH
`define PLL_REGS_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_PORT_CFG 8'h00
`define ADDR_READBACK 8'h04
`define ADDR_TRANSFER 8'h05
`define ADDR_PUMP_CODE 8'h0A
`define ADDR_LOOP_CTRL 8'h0B
`define ADDR_OFFSET 8'h0C
`define ADDR_ABL 8'h0D

// ----------------------------------------
// field positions
// ----------------------------------------
`define CFG_THREE_WIRE 7
`define CFG_LSB_FIRST 6
`define CFG_SOFT_RESET 5
`define CFG_LONG_INSTR 4
`define READBACK_SEL 0
`define XFER_START 0
`define LOOP_PUMP_OVR 7
`define LOOP_ABL_OVR 6
`define LOOP_MODE_HI 5
`define LOOP_MODE_LO 4
`define LOOP_MODE_OVR 3
`define LOOP_FB_EDGE 2
`define LOOP_REF_EDGE 1
`define LOOP_MIDSCALE 0
`define OFS_POLARITY 6
`define OFS_MAG_HI 5
`define OFS_MAG_LO 4
`define OFS_OVR 3
`define ABL_HI 7
`define ABL_LO 6
`define ABL_LOCKDET_PD 0

// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define RST_PUMP_CODE 8'h80
`define RST_LOOP_CTRL 8'h30
`define RST_OFFSET 8'h00
`define RST_ABL 8'h00
`define MASK_LOOP_CTRL 8'hFF
`define MASK_OFFSET 8'h78
`define MASK_ABL 8'hC1
`define PUMP_MODE_NORMAL 2'b11
`define ABL_MINIMUM 2'b00

`endif

// ---- logic/buffered_reg.v ----
/*
 holds: one buffered control register, a write buffer plus an active copy.
 assumes: the caller decodes the address and issues the transfer pulse.
*/
`timescale 1ns/1ps
`default_nettype none

module buffered_reg #(
   parameter [7:0] RESET_VALUE = 8'h00,
   parameter [7:0] WRITE_MASK = 8'hFF
) (
   input wire clock,
   input wire rst,
   input wire wr_en,
   input wire [7:0] wr_data,
   input wire transfer,
   output reg [7:0] buffer_q,
   output reg [7:0] active_q
);

   always @(posedge clock) begin
      if (rst) begin
         buffer_q <= RESET_VALUE;
         active_q <= RESET_VALUE;
      end else begin
         if (wr_en) begin
            buffer_q <= wr_data & WRITE_MASK;
         end
         // a write landing with the transfer is not in this copy yet
         if (transfer) begin
            active_q <= buffer_q;
         end
      end
   end

endmodule // buffered_reg

`default_nettype wire

// ---- tb/pll_regs_assertions.sv ----
/*
 holds: port-level assertions for the loop control register bank.
 assumes: bound to the bank's top module; rst is synchronous.
*/
`timescale 1ns/1ps
`default_nettype none

module pll_regs_checker (
   input wire clock,
   input wire rst,
   input wire wr_en,
   input wire rd_en,
   input wire [7:0] addr,
   input wire [7:0] wr_data,
   input wire [7:0] rd_data,
   input wire rd_valid,
   input wire lsb_first,
   input wire pump_current_override,
   input wire [7:0] pump_current,
   input wire pump_drive_mode_override,
   input wire [1:0] pump_drive_mode,
   input wire antibacklash_override,
   input wire [1:0] antibacklash_period,
   input wire offset_override,
   input wire [7:0] offset_current,
   input wire tuned_oscillator_midscale
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // a transfer or a soft reset are the only causes of a control change;
   // a transfer shows two edges later, a soft reset at the next edge
   wire xfer_w = wr_en && addr == 8'h05 && wr_data[0];
   wire soft_w = wr_en && addr == 8'h00 && wr_data[5];
   AST_CFG_FORCED: assert property (rd_en && addr == 8'h00 |=>
      !rd_data[7] && rd_data[4]) else $error("config forced bits wrong");
   AST_CFG_MIRROR: assert property (rd_en && addr == 8'h00 |=>
      rd_data[3:0] == rd_data[7:4]) else $error("config mirror wrong");
   AST_BIT_ORDER: assert property (wr_en && addr == 8'h00 |=>
      lsb_first == ($past(wr_data[6]) && !$past(wr_data[5])))
      else $error("bit order not taken");
   AST_SOFT_RESET: assert property (wr_en && addr == 8'h00 &&
      wr_data[5] |-> ##2 pump_current == 8'h80 && !offset_override &&
      !tuned_oscillator_midscale) else $error("soft reset missed");
   AST_READBACK_READ: assert property (rd_en && addr == 8'h04 |=>
      rd_valid && rd_data[7:1] == 7'h00) else $error("readback read bad");
   AST_XFER_READ: assert property (rd_en && addr == 8'h05 |=>
      rd_data == 8'h00) else $error("transfer bit stuck");
   AST_PUMP_AUTO: assert property (!pump_current_override |->
      pump_current == 8'h80) else $error("pump code leaks");
   AST_ABL_AUTO: assert property (!antibacklash_override |->
      antibacklash_period == 2'b00) else $error("period leaks");
   AST_MODE_AUTO: assert property (!pump_drive_mode_override |->
      pump_drive_mode == 2'b11) else $error("pump mode leaks");
   AST_OFS_AUTO: assert property (!offset_override |->
      offset_current == 8'h00) else $error("offset leaks");
   AST_BUFFERED: assert property ($changed(tuned_oscillator_midscale)
      |-> $past(xfer_w, 2) || $past(soft_w))
      else $error("control changed early");
endmodule // pll_regs_checker

`default_nettype wire

// ---- tb/host_port_model.sv ----
/*
 holds: host side of the byte port with write and read tasks.
 assumes: the bench calls the tasks; lines change on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

module host_port_model (
   input wire clock,
   output logic wr_en,
   output logic rd_en,
   output logic [7:0] addr,
   output logic [7:0] wr_data,
   input wire [7:0] rd_data
);
   initial begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      addr = 8'hff;
      wr_data = 8'h00;
   end
   // released lines carry the inverse so a stale value never passes
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      wr_en = 1'b1;
      addr = a;
      wr_data = d;
      @(negedge clock);
      wr_en = 1'b0;
      addr = ~a;
      wr_data = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock);
      rd_en = 1'b1;
      addr = a;
      @(negedge clock);
      rd_en = 1'b0;
      addr = ~a;
      d = rd_data;
   endtask
endmodule // host_port_model

`default_nettype wire

// ---- tb/pll_serial_control_regs_test.sv ----
/*
 holds: self-checking bench for the loop control register bank.
 assumes: the host model drives the byte port; run ends in complete_run.
*/
`timescale 1ns/1ps
`default_nettype none

module pll_serial_control_regs_test;
   logic clock, rst, wr_en, rd_en, rd_valid, lsb_first, pco, pmo, abo;
   logic fbf, rff, mid, ofo, opd, lpd;
   logic [1:0] pdm, abp, ofm;
   logic [7:0] addr, wr_data, rd_data, pump_current, offset_current, v;
   logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h05, 8'h0a, 8'h0b, 8'h0c,
      8'h0d, 8'h07};
   logic [7:0] rv [8] = '{8'h11, 8'h00, 8'h00, 8'h80, 8'h30, 8'h00,
      8'h00, 8'h00};
   int error_cnt = 0;
   int n_tests = 0;
   int cycles = 0;
   wire [7:0] flags = {pco, pmo, abo, fbf, rff, mid, ofo, lpd};
   wire [7:0] fields = {pdm, abp, ofm, opd, lsb_first};

   host_port_model host_port_model_i (.clock(clock), .wr_en(wr_en),
      .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data));
   pll_serial_control_regs pll_serial_control_regs_i (.clock(clock),
      .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
      .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
      .lsb_first(lsb_first), .pump_current_override(pco),
      .pump_current(pump_current), .pump_drive_mode_override(pmo),
      .pump_drive_mode(pdm), .antibacklash_override(abo),
      .antibacklash_period(abp), .phase_detector_fb_falling(fbf),
      .phase_detector_ref_falling(rff), .tuned_oscillator_midscale(mid),
      .offset_override(ofo), .offset_pump_down(opd),
      .offset_magnitude(ofm), .offset_current(offset_current),
      .lockdet_power_down(lpd));

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // controls land one edge after the transfer write is taken
   task automatic xfer;
      host_port_model_i.wr(8'h05, 8'h01);
      @(negedge clock);
   endtask
   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         error_cnt++;
         complete_run();
      end
   end

   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      repeat (16) @(negedge clock);
      rst = 1'b0;
      for (int i = 0; i < 8; i++) begin
         host_port_model_i.rd(ra[i], v);
         chk(v, rv[i]);
      end
      chk(flags, 8'h00);
      chk(fields, 8'hc0);
      $display("test defaults done");
      host_port_model_i.wr(8'h00, 8'hdf);
      host_port_model_i.rd(8'h00, v);
      chk(v, 8'h55);
      chk(fields, 8'hc1);
      host_port_model_i.wr(8'h00, 8'h00);
      $display("test port config done");
      host_port_model_i.wr(8'h0a, 8'h40);
      host_port_model_i.wr(8'h0b, 8'hff);
      host_port_model_i.wr(8'h0c, 8'hff);
      host_port_model_i.wr(8'h0d, 8'hff);
      host_port_model_i.rd(8'h0b, v);
      chk(v, 8'h30);
      chk(flags, 8'h00);
      host_port_model_i.wr(8'h04, 8'h01);
      host_port_model_i.rd(8'h0c, v);
      chk(v, 8'h78);
      host_port_model_i.rd(8'h0d, v);
      chk(v, 8'hc1);
      xfer();
      chk(flags, 8'hff);
      chk(fields, 8'hfe);
      chk(pump_current, 8'h40);
      chk(offset_current, 8'h04);
      host_port_model_i.rd(8'h05, v);
      chk(v, 8'h00);
      $display("test transfer done");
      for (logic [2:0] k = 0; k < 4; k++) begin
         host_port_model_i.wr(8'h0b, {2'b11, k[1:0], 4'h8});
         host_port_model_i.wr(8'h0c, {2'b00, k[1:0], 4'h8});
         host_port_model_i.wr(8'h0d, {k[1:0], 6'h00});
         xfer();
         chk(fields, {k[1:0], k[1:0], k[1:0], 2'b00});
         chk(flags, 8'he2);
         chk(offset_current, 8'h40 >> (k + 3'd1));
      end
      $display("test codes done");
      host_port_model_i.wr(8'h00, 8'h60);
      @(negedge clock);
      chk(flags, 8'h00);
      chk(fields, 8'hc0);
      host_port_model_i.rd(8'h04, v);
      chk(v, 8'h00);
      host_port_model_i.wr(8'h0a, 8'h10);
      host_port_model_i.wr(8'h0b, 8'h08);
      xfer();
      chk(pump_current, 8'h80);
      chk(flags, 8'h40);
      $display("test soft reset done");
      complete_run();
   end
endmodule // pll_serial_control_regs_test

bind pll_serial_control_regs pll_regs_checker pll_regs_checker_i (
   .clock(clock), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
   .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
   .lsb_first(lsb_first), .pump_current_override(pump_current_override),
   .pump_current(pump_current),
   .pump_drive_mode_override(pump_drive_mode_override),
   .pump_drive_mode(pump_drive_mode),
   .antibacklash_override(antibacklash_override),
   .antibacklash_period(antibacklash_period),
   .offset_override(offset_override), .offset_current(offset_current),
   .tuned_oscillator_midscale(tuned_oscillator_midscale));

`default_nettype wire
